// ### rtl/standard_event_notification_mask.sv
// standard notification pin mask register and event gating
`timescale 1ns/1ps
module standard_event_notification_mask #(
  parameter int N = evt_mask_pkg::EVT_N
) (
  input wire logic clk_sys, // 125 MHz device clock
  input wire logic arst_n, // async reset, active low
  input wire logic [15:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // registered read data
  output logic reg_hit, // registered: an access in the previous cycle hit this register
  input wire logic overcurrent_evt, // event levels from detectors
  input wire logic overvoltage_evt, // overvoltage active
  input wire logic overpower_evt, // overpower active
  input wire logic undervoltage_evt, // undervoltage active
  input wire logic overfrequency_evt, // overfrequency active
  input wire logic underfrequency_evt, // underfrequency active
  input wire logic overtemperature_evt, // overtemperature active
  input wire logic undertemperature_evt, // undertemperature active
  input wire logic voltage_sag_evt, // voltage sag active
  input wire logic voltage_surge_evt, // voltage surge active
  output logic [15:0] standard_event_pin_mask, // current mask value
  output logic notify_standard // standard notification pin level
);
  logic [N-1:0] mask_bits;
  logic [N-1:0] evt_vec;
  logic any_hit;
  logic [15:0] next_mask;
  logic [15:0] next_rdata;
  logic next_hit;
  logic sel;
  logic next_pin;
  // named mask fields, one per event
  logic overcurrent_mask;
  logic overvoltage_mask;
  logic overpower_mask;
  logic undervoltage_mask;
  logic overfrequency_mask;
  logic underfrequency_mask;
  logic overtemperature_mask;
  logic undertemperature_mask;
  logic voltage_sag_mask;
  logic voltage_surge_mask;

  assign sel = (reg_addr == evt_mask_pkg::STD_MASK_ADDR);
  assign mask_bits = standard_event_pin_mask[evt_mask_pkg::EVT_LSB +: N];

  // mask fields at their fixed bit positions, used by the checks below
  assign overcurrent_mask = standard_event_pin_mask[evt_mask_pkg::BIT_OVERCURRENT];
  assign overvoltage_mask = standard_event_pin_mask[evt_mask_pkg::BIT_OVERVOLTAGE];
  assign overpower_mask = standard_event_pin_mask[evt_mask_pkg::BIT_OVERPOWER];
  assign undervoltage_mask = standard_event_pin_mask[evt_mask_pkg::BIT_UNDERVOLTAGE];
  assign overfrequency_mask = standard_event_pin_mask[evt_mask_pkg::BIT_OVERFREQUENCY];
  assign underfrequency_mask = standard_event_pin_mask[evt_mask_pkg::BIT_UNDERFREQUENCY];
  assign overtemperature_mask = standard_event_pin_mask[evt_mask_pkg::BIT_OVERTEMPERATURE];
  assign undertemperature_mask = standard_event_pin_mask[evt_mask_pkg::BIT_UNDERTEMPERATURE];
  assign voltage_sag_mask = standard_event_pin_mask[evt_mask_pkg::BIT_VOLTAGE_SAG];
  assign voltage_surge_mask = standard_event_pin_mask[evt_mask_pkg::BIT_VOLTAGE_SURGE];

  // event vector packed in mask-bit order, bit 15 first
  assign evt_vec = {overcurrent_evt, overvoltage_evt, overpower_evt, undervoltage_evt,
                    overfrequency_evt, underfrequency_evt, overtemperature_evt,
                    undertemperature_evt, voltage_sag_evt, voltage_surge_evt};

  evt_gate #(.N(N)) u_gate (
    .events(evt_vec),
    .mask(mask_bits),
    .any_hit(any_hit)
  );

  // mask register; only a write that hits moves it, reserved bits dropped on entry
  always_comb begin
    next_mask = standard_event_pin_mask;
    if (reg_wr && sel) begin
      next_mask = reg_wdata & evt_mask_pkg::STD_MASK_IMPL;
    end
  end

  // cleared at power-on so no event reaches the pin before software opts in
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      standard_event_pin_mask <= evt_mask_pkg::STD_MASK_RESET;
    end else begin
      standard_event_pin_mask <= next_mask;
    end
  end

  // read port; a read beside a write in one cycle returns the old mask
  always_comb begin
    next_rdata = reg_rdata;
    next_hit = (reg_rd || reg_wr) && sel;
    if (reg_rd) begin
      // unmapped reads return zero rather than stale data
      next_rdata = sel ? (standard_event_pin_mask & evt_mask_pkg::STD_MASK_IMPL) : 16'h0000;
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  // pin level straight from the gate
  always_comb begin
    next_pin = any_hit;
  end

  // registered so the pin never glitches; costs one cycle of latency
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      notify_standard <= 1'b0;
    end else begin
      notify_standard <= next_pin;
    end
  end

  // reserved bits never hold a one, in the mask or on the read port
  a_low_bits_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (standard_event_pin_mask & ~evt_mask_pkg::STD_MASK_IMPL) == 16'h0000)
    else $error("unimplemented mask bits set");
  a_rdata_low_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rdata & ~evt_mask_pkg::STD_MASK_IMPL) == 16'h0000)
    else $error("unimplemented read bits set");

  // pin is the or of masked events, one cycle late
  a_pin_follows_or: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 notify_standard == $past(|(evt_vec & mask_bits)))
    else $error("pin not or of masked events");
  a_pin_deasserts: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ((evt_vec & mask_bits) == '0) |=> !notify_standard)
    else $error("pin high with no enabled event");
  a_masked_no_effect: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (mask_bits == '0) |=> !notify_standard)
    else $error("pin high with all masked");
  a_pin_any_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|(evt_vec & mask_bits)) |=> notify_standard)
    else $error("enabled event did not reach pin");
  a_multi_bits: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (voltage_surge_evt && mask_bits[0] && voltage_sag_evt && mask_bits[1]) |=> notify_standard)
    else $error("combined mask failed");

  // each field gates its own event; a swapped position would fail here
  a_field_pack: assert property (@(posedge clk_sys) disable iff (!arst_n)
    mask_bits == {overcurrent_mask, overvoltage_mask, overpower_mask, undervoltage_mask, overfrequency_mask,
                  underfrequency_mask, overtemperature_mask, undertemperature_mask, voltage_sag_mask,
                  voltage_surge_mask})
    else $error("mask field order wrong");
  a_enabled_drives: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overcurrent_evt && mask_bits[N-1]) |=> notify_standard)
    else $error("overcurrent not driven");
  a_map_overcurrent: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overcurrent_evt && overcurrent_mask) |=> notify_standard)
    else $error("overcurrent field not driven");
  a_map_overvoltage: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overvoltage_evt && overvoltage_mask) |=> notify_standard)
    else $error("overvoltage field not driven");
  a_map_overpower: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overpower_evt && overpower_mask) |=> notify_standard)
    else $error("overpower field not driven");
  a_map_undervoltage: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (undervoltage_evt && undervoltage_mask) |=> notify_standard)
    else $error("undervoltage field not driven");
  a_map_overfrequency: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overfrequency_evt && overfrequency_mask) |=> notify_standard)
    else $error("overfrequency field not driven");
  a_map_underfrequency: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (underfrequency_evt && underfrequency_mask) |=> notify_standard)
    else $error("underfrequency field not driven");
  a_map_overtemperature: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (overtemperature_evt && overtemperature_mask) |=> notify_standard)
    else $error("overtemperature field not driven");
  a_map_undertemperature: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (undertemperature_evt && undertemperature_mask) |=> notify_standard)
    else $error("undertemperature field not driven");
  a_map_voltage_sag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (voltage_sag_evt && voltage_sag_mask) |=> notify_standard)
    else $error("voltage sag field not driven");
  a_map_voltage_surge: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (voltage_surge_evt && voltage_surge_mask) |=> notify_standard)
    else $error("voltage surge field not driven");

  // mask moves only on a write that hits, and takes the written value with reserved bits cleared
  a_write_lands: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && sel) |=> standard_event_pin_mask == ($past(reg_wdata) & evt_mask_pkg::STD_MASK_IMPL))
    else $error("write lost");
  a_no_stray_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(reg_wr && sel) |=> $stable(standard_event_pin_mask))
    else $error("mask changed unexpectedly");

  // read port returns the mask, zero elsewhere, and holds between reads
  a_read_value: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && sel && !reg_wr) |=> reg_rdata == $past(standard_event_pin_mask))
    else $error("read mismatch");
  a_rd_wr_old: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_wr && sel) |=> reg_rdata == $past(standard_event_pin_mask))
    else $error("read beside write not old value");
  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && !sel) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_hit_on_access: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ((reg_rd || reg_wr) && sel) |=> reg_hit)
    else $error("hit flag missing");
  a_hit_off_miss: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !((reg_rd || reg_wr) && sel) |=> !reg_hit)
    else $error("hit flag without access");
endmodule

// ### rtl/evt_mask_pkg.sv
// constants for the standard event notification mask block
package evt_mask_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 16;
  localparam int EVT_N = 10;
  localparam logic [15:0] STD_MASK_ADDR = 16'h008e;
  localparam logic [15:0] STD_MASK_RESET = 16'h0000;
  // bits 15..6 implemented, 5..0 read as zero
  localparam logic [15:0] STD_MASK_IMPL = 16'hffc0;
  localparam int EVT_LSB = 6;
  localparam int BIT_OVERCURRENT = 15;
  localparam int BIT_OVERVOLTAGE = 14;
  localparam int BIT_OVERPOWER = 13;
  localparam int BIT_UNDERVOLTAGE = 12;
  localparam int BIT_OVERFREQUENCY = 11;
  localparam int BIT_UNDERFREQUENCY = 10;
  localparam int BIT_OVERTEMPERATURE = 9;
  localparam int BIT_UNDERTEMPERATURE = 8;
  localparam int BIT_VOLTAGE_SAG = 7;
  localparam int BIT_VOLTAGE_SURGE = 6;
endpackage

// ### rtl/evt_gate.sv
// and-or reduction of event levels against their mask bits
`timescale 1ns/1ps
module evt_gate #(
  parameter int N = 10
) (
  input wire logic [N-1:0] events, // active event levels
  input wire logic [N-1:0] mask, // per-event enables
  output logic any_hit // one when an enabled event is active
);
  // any enabled event raises the pin
  assign any_hit = |(events & mask);
endmodule

// ### tb/standard_event_notification_mask_tb.sv
// self-checking bench for the standard event notification mask block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module standard_event_notification_mask_tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] mask_q;
  logic reg_hit;
  logic notify_standard;
  logic [9:0] evt = 10'h000; // bit 9 overcurrent down to bit 0 surge
  int bad_count = 0;
  int checked = 0;
  standard_event_notification_mask dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .overcurrent_evt(evt[9]),
    .overvoltage_evt(evt[8]), .overpower_evt(evt[7]), .undervoltage_evt(evt[6]), .overfrequency_evt(evt[5]),
    .underfrequency_evt(evt[4]), .overtemperature_evt(evt[3]), .undertemperature_evt(evt[2]),
    .voltage_sag_evt(evt[1]), .voltage_surge_evt(evt[0]), .standard_event_pin_mask(mask_q),
    .notify_standard(notify_standard));
  // free-running clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // strobes last one cycle, driven off the sampling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
    `CHK(reg_hit, a == evt_mask_pkg::STD_MASK_ADDR)
  endtask
  // pin is registered, so look one cycle after the change
  task automatic pin(input logic [9:0] ev, input logic e);
    @(negedge clk_sys);
    evt = ev;
    @(negedge clk_sys);
    `CHK(notify_standard, e)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // whole run is about 115 cycles; this only cuts a hang
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    `CHK(mask_q, evt_mask_pkg::STD_MASK_RESET)
    rd(evt_mask_pkg::STD_MASK_ADDR, 16'h0000);
    wr(evt_mask_pkg::STD_MASK_ADDR, 16'hffff);
    rd(evt_mask_pkg::STD_MASK_ADDR, 16'hffc0);
    wr(16'h008c, 16'h0000);
    rd(16'h008c, 16'h0000);
    rd(evt_mask_pkg::STD_MASK_ADDR, 16'hffc0);
    pin(10'h201, 1'b1);
    pin(10'h003, 1'b1);
    // read and write in one cycle: read returns the old mask
    @(negedge clk_sys);
    reg_addr = evt_mask_pkg::STD_MASK_ADDR;
    reg_wdata = 16'h8001;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    `CHK(reg_rdata, 16'hffc0)
    `CHK(mask_q, 16'h8000)
    `CHK(reg_hit, 1'b1)
    $display("register test done");
    // one mask bit at a time: others active must not reach the pin
    for (int i = 0; i < 10; i++) begin
      wr(evt_mask_pkg::STD_MASK_ADDR, 16'h0040 << i);
      pin(~(10'h001 << i), 1'b0);
      pin(10'h001 << i, 1'b1);
      pin(10'h000, 1'b0);
    end
    // every event active with all masked keeps the pin low
    wr(evt_mask_pkg::STD_MASK_ADDR, 16'h0000);
    pin(10'h3ff, 1'b0);
    wr(evt_mask_pkg::STD_MASK_ADDR, 16'hffc0);
    pin(10'h3ff, 1'b1);
    $display("gating test done");
    // mid-run reset clears mask and pin although events stay active
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    `CHK(mask_q, evt_mask_pkg::STD_MASK_RESET)
    `CHK(notify_standard, 1'b0)
    pin(10'h3ff, 1'b0);
    rd(evt_mask_pkg::STD_MASK_ADDR, 16'h0000);
    $display("reset test done");
    print_verdict();
  end
endmodule
